// *** hdl/rtc_pkg.sv ***
package rtc_pkg;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ = 100_000_000;
  localparam int unsigned OSC_HZ = 32768;
  // core cycles per 32-kHz tick, rounded down
  localparam int unsigned OSC_DIV = CORE_CLK_HZ / OSC_HZ;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_IRQ_CTRL = 4'h2;
  localparam logic [3:0] OFS_COMP_LO = 4'h3;
  localparam logic [3:0] OFS_COMP_HI = 4'h4;
  localparam logic [3:0] OFS_TIME = 4'h5;
  localparam logic [3:0] OFS_ALARM = 4'h9;
  localparam logic [3:0] OFS_SUBSEC_LO = 4'hd;
  localparam logic [3:0] OFS_SUBSEC_HI = 4'he;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN = 0;
  localparam int CTRL_DRIFT = 1;
  localparam int CTRL_PRELOAD = 2;
  localparam int ST_RUNNING = 0;
  localparam int ST_PENDING = 1;
  localparam int IRQ_PER_LSB = 0;
  localparam int IRQ_PER_EN = 2;
  localparam int IRQ_ALARM_EN = 3;
  localparam int IRQ_DEFER = 4;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [15:0] COMP_RST = 16'h0000;
  localparam logic [7:0] TIME_RST = 8'h00;
  localparam logic [16:0] SUBSEC_NOMINAL = 17'h08000;
  localparam logic [7:0] SEC_LAST = 8'h3b;
  localparam logic [7:0] MIN_LAST = 8'h3b;
  localparam logic [7:0] HOUR_LAST = 8'h17;
  localparam logic [7:0] DAY_LAST = 8'hff;
  localparam int TIME_FIELDS = 4;

  typedef enum logic [1:0] {
    PER_SECOND = 2'b00,
    PER_MINUTE = 2'b01,
    PER_HOUR = 2'b10,
    PER_DAY = 2'b11
  } period_type;

  function automatic logic [7:0] field_last(input int idx);
    case (idx)
      0: field_last = SEC_LAST;
      1: field_last = MIN_LAST;
      2: field_last = HOUR_LAST;
      default: field_last = DAY_LAST;
    endcase
  endfunction

endpackage

// *** hdl/osc_divider.sv ***
`timescale 1ns/1ps
module osc_divider #(
  parameter int unsigned DIV = 3051
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // enable out
  output logic tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic next_tick;

  always_comb begin
    next_tick = (count == LAST);
    next_count = next_tick ? '0 : count + CW'(1);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

endmodule // osc_divider

// *** hdl/rtc_irq_drift_comp.sv ***
`timescale 1ns/1ps
module rtc_irq_drift_comp #(
  parameter int unsigned TICK_DIV = rtc_pkg::OSC_DIV
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // register port
  input wire logic [rtc_pkg::ADDR_W-1:0] addr,
  input wire logic [rtc_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [rtc_pkg::DATA_W-1:0] rd_data,
  // power state
  input wire logic sleep_state,
  // interrupts
  output logic alarm_irq,
  output logic timer_irq
);
  import rtc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic osc_tick;
  logic run_en, drift_en, running;
  period_type period_select;
  logic periodic_irq_enable, alarm_irq_enable, sleep_defer_enable;
  logic [15:0] comp;
  logic [15:0] subsec;
  logic [7:0] time_q [TIME_FIELDS];
  logic [7:0] alarm_q [TIME_FIELDS];
  logic timer_pending;

  logic next_run_en, next_drift_en, next_running;
  period_type next_period_select;
  logic next_periodic_irq_enable, next_alarm_irq_enable;
  logic next_sleep_defer_enable;
  logic [15:0] next_comp, next_subsec;
  logic [7:0] next_time [TIME_FIELDS];
  logic [7:0] next_alarm [TIME_FIELDS];
  logic next_timer_pending, next_alarm_irq, next_timer_irq;
  logic [DATA_W-1:0] next_rd_data;

  logic adjusted_second;
  logic [16:0] limit;
  logic sec_tick, carry, alarm_match, timer_evt, alarm_evt;
  logic deliver, hold;
  logic [TIME_FIELDS-1:0] rolled;

  // ----------------------------------------------------------------
  // 32-kHz enable
  // ----------------------------------------------------------------
  osc_divider #(
    .DIV(TICK_DIV)
  ) u_div (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick(osc_tick)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_run_en = run_en;
    next_drift_en = drift_en;
    next_running = running;
    next_period_select = period_select;
    next_periodic_irq_enable = periodic_irq_enable;
    next_alarm_irq_enable = alarm_irq_enable;
    next_sleep_defer_enable = sleep_defer_enable;
    next_comp = comp;
    next_subsec = subsec;
    next_alarm = alarm_q;
    next_time = time_q;
    next_rd_data = '0;
    rolled = '0;

    // freeze takes hold at a tick boundary, so the flag is honest
    if (osc_tick) begin
      next_running = run_en;
    end

    // hourly window is second 1 to 2 of minute 0
    adjusted_second = drift_en && (time_q[0] == 8'h01) &&
                      (time_q[1] == 8'h00);
    // sign-extended subtraction covers -32768..32767 in 17 bits
    limit = adjusted_second ?
            SUBSEC_NOMINAL - {comp[15], comp} : SUBSEC_NOMINAL;
    sec_tick = osc_tick && running &&
               ({1'b0, subsec} >= limit - 17'h00001);
    if (osc_tick && running) begin
      next_subsec = sec_tick ? 16'h0000 : subsec + 16'h0001;
    end

    carry = sec_tick;
    for (int i = 0; i < TIME_FIELDS; i++) begin
      if (carry) begin
        if (time_q[i] >= field_last(i)) begin
          next_time[i] = TIME_RST;
          rolled[i] = 1'b1;
        end else begin
          next_time[i] = time_q[i] + 8'h01;
          carry = 1'b0;
        end
      end
    end

    alarm_match = 1'b1;
    for (int i = 0; i < TIME_FIELDS; i++) begin
      if (next_time[i] != alarm_q[i]) begin
        alarm_match = 1'b0;
      end
    end
    alarm_evt = sec_tick && alarm_match;

    case (period_select)
      PER_SECOND: timer_evt = sec_tick;
      PER_MINUTE: timer_evt = rolled[0];
      PER_HOUR: timer_evt = rolled[1];
      PER_DAY: timer_evt = rolled[2];
      default: timer_evt = 1'b0;
    endcase
    timer_evt = timer_evt && periodic_irq_enable;

    // a pending event survives; a new one in the release cycle too
    deliver = (timer_evt || timer_pending) && periodic_irq_enable;
    hold = sleep_state && sleep_defer_enable;
    next_timer_pending = hold && deliver;
    next_timer_irq = !hold && deliver;
    next_alarm_irq = alarm_evt && alarm_irq_enable;

    // software writes win over the running count
    if (wr_en) begin
      case (addr)
        OFS_CTRL: begin
          next_run_en = wr_data[CTRL_RUN];
          next_drift_en = wr_data[CTRL_DRIFT];
          if (wr_data[CTRL_PRELOAD]) begin
            next_subsec = comp;
          end
        end
        OFS_IRQ_CTRL: begin
          next_period_select =
            period_type'(wr_data[IRQ_PER_LSB +: 2]);
          next_periodic_irq_enable = wr_data[IRQ_PER_EN];
          next_alarm_irq_enable = wr_data[IRQ_ALARM_EN];
          next_sleep_defer_enable = wr_data[IRQ_DEFER];
        end
        OFS_COMP_LO: next_comp[7:0] = wr_data;
        OFS_COMP_HI: next_comp[15:8] = wr_data;
        OFS_TIME, OFS_TIME + 4'h1, OFS_TIME + 4'h2, OFS_TIME + 4'h3:
          next_time[2'(addr - OFS_TIME)] = wr_data;
        OFS_ALARM, OFS_ALARM + 4'h1, OFS_ALARM + 4'h2, OFS_ALARM + 4'h3:
          next_alarm[2'(addr - OFS_ALARM)] = wr_data;
        default: ;
      endcase
    end

    if (rd_en) begin
      case (addr)
        OFS_CTRL: next_rd_data = {6'h00, drift_en, run_en};
        OFS_STATUS: next_rd_data = {6'h00, timer_pending, running};
        OFS_IRQ_CTRL: next_rd_data = {3'h0, sleep_defer_enable,
                                      alarm_irq_enable,
                                      periodic_irq_enable, period_select};
        OFS_COMP_LO: next_rd_data = comp[7:0];
        OFS_COMP_HI: next_rd_data = comp[15:8];
        OFS_TIME, OFS_TIME + 4'h1, OFS_TIME + 4'h2, OFS_TIME + 4'h3:
          next_rd_data = time_q[2'(addr - OFS_TIME)];
        OFS_ALARM, OFS_ALARM + 4'h1, OFS_ALARM + 4'h2, OFS_ALARM + 4'h3:
          next_rd_data = alarm_q[2'(addr - OFS_ALARM)];
        OFS_SUBSEC_LO: next_rd_data = subsec[7:0];
        OFS_SUBSEC_HI: next_rd_data = subsec[15:8];
        default: next_rd_data = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_en <= 1'b0;
      drift_en <= 1'b0;
      running <= 1'b0;
      period_select <= PER_SECOND;
      periodic_irq_enable <= 1'b0;
      alarm_irq_enable <= 1'b0;
      sleep_defer_enable <= 1'b0;
      comp <= COMP_RST;
      subsec <= 16'h0000;
      timer_pending <= 1'b0;
      alarm_irq <= 1'b0;
      timer_irq <= 1'b0;
      rd_data <= '0;
      for (int i = 0; i < TIME_FIELDS; i++) begin
        time_q[i] <= TIME_RST;
        alarm_q[i] <= TIME_RST;
      end
    end else begin
      run_en <= next_run_en;
      drift_en <= next_drift_en;
      running <= next_running;
      period_select <= next_period_select;
      periodic_irq_enable <= next_periodic_irq_enable;
      alarm_irq_enable <= next_alarm_irq_enable;
      sleep_defer_enable <= next_sleep_defer_enable;
      comp <= next_comp;
      subsec <= next_subsec;
      timer_pending <= next_timer_pending;
      alarm_irq <= next_alarm_irq;
      timer_irq <= next_timer_irq;
      rd_data <= next_rd_data;
      time_q <= next_time;
      alarm_q <= next_alarm;
    end
  end

endmodule // rtc_irq_drift_comp

// *** tb/rtc_irq_properties.sv ***
`timescale 1ns/1ps
module rtc_irq_checker
  import rtc_pkg::*;
#(
  parameter int unsigned TICK_DIV = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  // power and interrupts
  input wire logic sleep_state,
  input wire logic alarm_irq,
  input wire logic timer_irq
);
  // ---------------------------------------------------------------
  // shadow of software settings
  // ---------------------------------------------------------------
  logic [4:0] irq_sh, next_irq_sh;
  logic run_sh, next_run_sh;
  int stop_cnt, next_stop_cnt;
  always_comb begin
    next_irq_sh = irq_sh;
    next_run_sh = run_sh;
    // saturate so a long stop never wraps back into range
    next_stop_cnt = run_sh ? 0 : (stop_cnt < 1000 ? stop_cnt + 1 : stop_cnt);
    if (wr_en && addr == OFS_IRQ_CTRL) next_irq_sh = wr_data[4:0];
    if (wr_en && addr == OFS_CTRL) next_run_sh = wr_data[CTRL_RUN];
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_sh <= '0;
      run_sh <= 1'b0;
      stop_cnt <= 0;
    end else begin
      irq_sh <= next_irq_sh;
      run_sh <= next_run_sh;
      stop_cnt <= next_stop_cnt;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence rd_irq;
    rd_en && addr == OFS_IRQ_CTRL;
  endsequence
  sequence defer_held;
    (sleep_state && irq_sh[IRQ_DEFER]) [*2];
  endsequence
  AST_TIMER_PULSE: assert property (timer_irq |=> !timer_irq [*8])
    else $error("timer pulse too long");
  AST_ALARM_PULSE: assert property (alarm_irq |=> !alarm_irq [*8])
    else $error("alarm pulse too long");
  // enable as it stood when the event was registered
  AST_ALARM_EN: assert property (alarm_irq |-> $past(irq_sh[IRQ_ALARM_EN]))
    else $error("alarm while disabled");
  AST_TIMER_EN: assert property (timer_irq |-> $past(irq_sh[IRQ_PER_EN]))
    else $error("timer while disabled");
  AST_DEFER: assert property (defer_held |-> !timer_irq)
    else $error("timer during deferred sleep");
  AST_STOPPED: assert property ((timer_irq || alarm_irq) |->
    stop_cnt < 3 * TICK_DIV + 2) else $error("event while stopped");
  AST_IRQ_RB: assert property (rd_irq |=> rd_data == {3'h0, irq_sh})
    else $error("irq control readback");
  AST_RD_IDLE: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data outside slot");
endmodule // rtc_irq_checker

// *** tb/tb_rtc_irq_drift_comp.sv ***
`timescale 1ns/1ps
module tb_rtc_irq_drift_comp;
  import rtc_pkg::*;
  logic core_clk = 0, arst_n = 0, wr_en = 0, rd_en = 0, sleep_state = 0;
  logic [3:0] addr = '0;
  logic [7:0] wr_data = '0, rd_data, q;
  logic alarm_irq, timer_irq;
  int n_mismatch = 0, num_checks = 0, cyc = 0, nt, na;
  typedef struct packed {logic [7:0] ic, s, m, h; logic sl, et;} row_type;
  // irq control, start time, sleep, expected timer event
  row_type rows [9] = '{'{8'h04, 8'h05, 8'h00, 8'h00, 1'b0, 1'b1},
    '{8'h00, 8'h05, 8'h00, 8'h00, 1'b0, 1'b0},
    '{8'h05, 8'h3b, 8'h00, 8'h00, 1'b0, 1'b1},
    '{8'h05, 8'h05, 8'h00, 8'h00, 1'b0, 1'b0},
    '{8'h06, 8'h3b, 8'h3b, 8'h00, 1'b0, 1'b1},
    '{8'h06, 8'h3b, 8'h05, 8'h00, 1'b0, 1'b0},
    '{8'h07, 8'h3b, 8'h3b, 8'h17, 1'b0, 1'b1},
    '{8'h07, 8'h3b, 8'h3b, 8'h05, 1'b0, 1'b0},
    '{8'h04, 8'h05, 8'h00, 8'h00, 1'b1, 1'b1}};
  rtc_irq_drift_comp #(.TICK_DIV(4)) uut (.core_clk(core_clk),
    .arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .sleep_state(sleep_state),
    .alarm_irq(alarm_irq), .timer_irq(timer_irq));
  initial forever #5 core_clk = ~core_clk;
  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 q = rd_data;
  endtask
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic watch(input int n);
    nt = 0;
    na = 0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (timer_irq === 1'b1) nt++;
      if (alarm_irq === 1'b1) na++;
    end
  endtask
  // stop, preload the sub-second counter, load the time
  task automatic setup(input logic [7:0] s, m, h, input logic [15:0] p);
    wr(OFS_CTRL, 8'h00);
    repeat (12) @(posedge core_clk);
    rd(OFS_STATUS);
    chk(q[ST_RUNNING] === 1'b0, "still running");
    wr(OFS_COMP_LO, p[7:0]);
    wr(OFS_COMP_HI, p[15:8]);
    wr(OFS_CTRL, 8'h04);
    wr(OFS_TIME, s);
    wr(OFS_TIME + 4'h1, m);
    wr(OFS_TIME + 4'h2, h);
    wr(OFS_TIME + 4'h3, 8'h00);
  endtask
  // preload near the wrap so the next second comes within a few ticks
  task automatic adv(input logic [7:0] s, m, h);
    setup(s, m, h, 16'h7fff);
    wr(OFS_CTRL, 8'h01);
    watch(40);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0]);
      chk(q === 8'h00, "reset or unmapped value");
    end
    foreach (rows[i]) begin
      wr(OFS_IRQ_CTRL, rows[i].ic);
      rd(OFS_IRQ_CTRL);
      chk(q === rows[i].ic, "irq control");
      sleep_state <= rows[i].sl;
      adv(rows[i].s, rows[i].m, rows[i].h);
      chk(nt == rows[i].et && na == 0, "timer event");
      sleep_state <= 1'b0;
    end
    wr(OFS_ALARM, 8'h0b);
    for (int e = 0; e < 3; e++) begin
      wr(OFS_IRQ_CTRL, e > 0 ? 8'h08 : 8'h00);
      adv(e == 2 ? 8'h0c : 8'h0a, 8'h00, 8'h00);
      chk(na == (e == 1), "alarm event");
    end
    wr(OFS_IRQ_CTRL, 8'h14);
    sleep_state <= 1'b1;
    adv(8'h05, 8'h00, 8'h00);
    chk(nt == 0, "timer not held");
    rd(OFS_STATUS);
    chk(q[ST_PENDING] === 1'b1, "no pending flag");
    sleep_state <= 1'b0;
    watch(4);
    chk(nt == 1, "held timer not released");
    // short, nominal, wrong minute, negative value
    for (int k = 0; k < 4; k++) begin
      wr(OFS_IRQ_CTRL, 8'h04);
      setup(8'h01, k == 2 ? 8'h01 : 8'h00, 8'h00, 16'h0000);
      wr(OFS_COMP_LO, 8'hf8);
      wr(OFS_COMP_HI, k == 3 ? 8'hff : 8'h7f);
      wr(OFS_CTRL, k == 1 ? 8'h01 : 8'h03);
      watch(60);
      rd(OFS_TIME);
      chk(nt == (k == 0) && q === (k == 0 ? 8'h02 : 8'h01),
        "adjusted_second length");
    end
    // mid-run reset must stop the clock and clear the irq control settings
    rd(OFS_STATUS);
    chk(q === 8'h01, "not running before reset");
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(rd_data === 8'h00 && timer_irq === 1'b0 && alarm_irq === 1'b0,
      "outputs during reset");
    arst_n <= 1'b1;
    for (int a = 0; a < 3; a++) begin
      rd(a[3:0]);
      chk(q === 8'h00, "value after mid-run reset");
    end
    final_report();
  end
endmodule // tb_rtc_irq_drift_comp
bind rtc_irq_drift_comp rtc_irq_checker #(.TICK_DIV(TICK_DIV)) props (
  .core_clk(core_clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .sleep_state(sleep_state), .alarm_irq(alarm_irq), .timer_irq(timer_irq));
